// [hw/pbc_pkg.sv]
// polling bit-check controller: shared register map, field layout, reset values and counts
// assumes a 32-bit AXI4-Lite register port with byte addresses in the low four bits
package pbc_pkg;

  // register byte offsets
  localparam logic [3:0]  PBC_OFF_OPCFG  = 4'h0;
  localparam logic [3:0]  PBC_OFF_WIN    = 4'h4;
  localparam logic [3:0]  PBC_OFF_STATUS = 4'h8;
  localparam logic [3:0]  PBC_OFF_CMD    = 4'hC;

  // operating_config_reg fields
  localparam int          PBC_OPCFG_SLEEP_LSB = 0;
  localparam int          PBC_OPCFG_XSEL_BIT  = 5;
  localparam int          PBC_OPCFG_NCHK_LSB  = 6;
  localparam int          PBC_OPCFG_RATE_LSB  = 8;
  localparam int          PBC_OPCFG_W         = 10;

  // check-window register fields
  localparam int          PBC_WIN_LO_LSB = 0;
  localparam int          PBC_WIN_HI_LSB = 8;
  localparam int          PBC_WIN_W      = 16;

  // command register: write one returns to polling
  localparam int          PBC_CMD_POLL_BIT = 0;

  // status register fields
  localparam int          PBC_ST_STATE_LSB  = 0;
  localparam int          PBC_ST_ACT_BIT    = 2;
  localparam int          PBC_ST_FORCE_BIT  = 3;
  localparam int          PBC_ST_PASS_LSB   = 8;
  localparam int          PBC_ST_ICNT_LSB   = 16;

  // reset values: sleep 1, 3 check bits, range 0; window 14..24
  localparam logic [9:0]  PBC_OPCFG_RST = 10'h041;
  localparam logic [15:0] PBC_WIN_RST   = 16'h180E;

  // timing counts
  localparam int          PBC_DIV_STD          = 28;
  localparam int          PBC_DIV_ALT          = 30;
  localparam int          PBC_SLEEP_SHIFT_STD  = 10;
  localparam int          PBC_XMULT_LOG2       = 3;
  localparam int          PBC_SLEEP_SHIFT_EXT  = PBC_SLEEP_SHIFT_STD + PBC_XMULT_LOG2;
  localparam logic [4:0]  PBC_SLEEP_PERM       = 5'h1F;
  localparam logic [3:0]  PBC_XTICK_MAX_BASE   = 4'h8;
  localparam int          PBC_BITS_PER_STEP    = 3;
  localparam int          PBC_CHECKS_PER_BIT   = 2;
  localparam int          PBC_STARTUP_TICKS    = 32;

  // AXI responses
  localparam logic [1:0]  PBC_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  PBC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PBC_ST_SLEEP   = 2'b00,
    PBC_ST_STARTUP = 2'b01,
    PBC_ST_CHECK   = 2'b10,
    PBC_ST_RECEIVE = 2'b11
  } pbc_state_t;

endpackage : pbc_pkg

// [hw/pbc_tick_div.sv]
// base tick divider: one-cycle pulse every DIV enabled clock cycles
// assumes clk_in is the crystal-derived clock and clr_in is synchronous
`timescale 1ns/10ps
module pbc_tick_div
  import pbc_pkg::*;
#(
  parameter int DIV = PBC_DIV_STD
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic ce_in,
  input  wire logic clr_in,
  output logic      tick_out
);

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } pbc_div_t;

  localparam logic [4:0] LAST = 5'(DIV - 1);

  pbc_div_t cur;
  pbc_div_t next_cur;

  always_comb begin
    next_cur      = cur;
    next_cur.tick = 1'b0;
    if (clr_in) begin
      next_cur.cnt = 5'h00;
    end else if (cur.cnt == LAST) begin
      next_cur.cnt  = 5'h00;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.cnt = cur.cnt + 5'h01;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur <= '0;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign tick_out = cur.tick & ce_in;

endmodule : pbc_tick_div

// [hw/pbc_ctrl.sv]
// polling controller: sleep / start-up / bit-check / receive sequencer with AXI4-Lite registers
// assumes ref_clk_in stands for the crystal oscillator clock; demod_in and poll_sel_n_in are
// asynchronous pins and are synchronised here
`timescale 1ns/10ps
// Function
// - base tick is the oscillator clock divided by 28 or 30 by variant
// - extended tick spans 8, 4, 2 or 1 base ticks for rate band 0..3
// - polling loops sleep, start-up, bit check; failed check returns to sleep
// - signal processing off in sleep, enabled and settling during start-up
// - activity indicator low while sleeping, high in any active state
// - sleep time is sleep setting times multiplier times 1024 base ticks
// - sleep multiplier is 8 when the extension select bit is set, else 1
// - maximum sleep setting means permanent sleep until another value is written
// - in permanent sleep the polling-select pin switches the receiver on and off
// - check-bit setting picks 0, 3, 6 or 9 bits, two interval checks each
// - enough consecutive passing checks move bit check to receiving mode
// - an interval outside the window aborts bit check back to sleep
// - lower window is low limit ticks, upper is high limit minus one ticks
// - low and high limits are 5-bit fields of the check-window register
// - interval counter advances on extended ticks and is compared at edges
// - counter reaching high limit fails at once; early edge below low fails
// - demodulator edges are ignored during start-up
// - receiving mode holds until an explicit return to polling
// - polling-select low forces start-up from sleep, ignoring but keeping sleep and check settings; a running bit check goes on
module pbc_ctrl
  import pbc_pkg::*;
#(
  parameter int VARIANT_DIV   = PBC_DIV_STD,
  parameter int STARTUP_TICKS = PBC_STARTUP_TICKS
) (
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  input  wire logic        ce_in,
  input  wire logic        demod_in,
  input  wire logic        poll_sel_n_in,
  output logic             activity_indicator_out,
  output logic             sig_proc_en_out,
  output logic             receiving_out,
  input  wire logic [3:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [3:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in
);

  typedef struct packed {
    logic [2:0]            demod_sync;
    logic [2:0]            poll_sync;
    logic                  demod_lvl;
    logic                  poll_lvl;
    pbc_state_t            state;
    logic [17:0]           sleep_cnt;
    logic [15:0]           start_cnt;
    logic [2:0]            xcnt;
    logic [5:0]            icnt;
    logic                  armed;
    logic [4:0]            passes;
    logic [PBC_OPCFG_W-1:0] opcfg;
    logic [PBC_WIN_W-1:0]  win;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } pbc_regs_t;

  localparam logic [15:0] START_LAST = 16'(STARTUP_TICKS - 1);

  localparam pbc_regs_t REGS_RST = '{
    demod_sync: 3'h0,
    poll_sync:  3'h7,
    demod_lvl:  1'b0,
    poll_lvl:   1'b1,
    state:      PBC_ST_SLEEP,
    sleep_cnt:  18'h00000,
    start_cnt:  16'h0000,
    xcnt:       3'h0,
    icnt:       6'h00,
    armed:      1'b0,
    passes:     5'h00,
    opcfg:      PBC_OPCFG_RST,
    win:        PBC_WIN_RST,
    bvalid:     1'b0,
    bresp:      PBC_RESP_OKAY,
    rvalid:     1'b0,
    rdata:      32'h00000000,
    rresp:      PBC_RESP_OKAY
  };

  pbc_regs_t cur;
  pbc_regs_t next_cur;

  logic        base_tick;
  logic        div_clr;
  logic        wr_go;
  logic        rd_go;

  // byte-lane merge of a write into the current register contents
  function automatic logic [31:0] pbc_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : pbc_merge

  // base divider free-runs; only the extended tick counter restarts at check entry
  assign div_clr = 1'b0;

  pbc_tick_div #(
    .DIV (VARIANT_DIV)
  ) u_base_div (
    .clk_in    (ref_clk_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .clr_in    (div_clr),
    .tick_out  (base_tick)
  );

  // bus handshakes are combinational and frozen with the clock enable
  assign wr_go             = ce_in & s_axi_awvalid_in & s_axi_wvalid_in & ~cur.bvalid;
  assign rd_go             = ce_in & s_axi_arvalid_in & ~cur.rvalid;
  assign s_axi_awready_out = wr_go;
  assign s_axi_wready_out  = wr_go;
  assign s_axi_arready_out = rd_go;

  always_comb begin
    logic [4:0]  sleep_v;
    logic        xsel;
    logic [1:0]  nchk;
    logic [1:0]  rate;
    logic [4:0]  lo_lim;
    logic [4:0]  hi_lim;
    logic [17:0] sleep_target;
    logic [3:0]  xlen;
    logic        xtick;
    logic [4:0]  req_checks;
    logic        perm;
    logic        forced;
    logic        poll_rise;
    logic        edge_seen;
    logic        back_to_poll;
    logic [31:0] wmerged;
    logic [31:0] status;

    next_cur     = cur;
    edge_seen    = 1'b0;
    forced       = 1'b0;
    poll_rise    = 1'b0;
    back_to_poll = 1'b0;
    wmerged      = 32'h00000000;
    status       = 32'h00000000;

    sleep_v      = cur.opcfg[PBC_OPCFG_SLEEP_LSB +: 5];
    xsel         = cur.opcfg[PBC_OPCFG_XSEL_BIT];
    nchk         = cur.opcfg[PBC_OPCFG_NCHK_LSB +: 2];
    rate         = cur.opcfg[PBC_OPCFG_RATE_LSB +: 2];
    lo_lim       = cur.win[PBC_WIN_LO_LSB +: 5];
    hi_lim       = cur.win[PBC_WIN_HI_LSB +: 5];
    sleep_target = 18'(sleep_v) << (xsel ? PBC_SLEEP_SHIFT_EXT
                                         : PBC_SLEEP_SHIFT_STD);
    xlen         = PBC_XTICK_MAX_BASE >> rate;
    xtick        = base_tick && (cur.xcnt == 3'(xlen - 4'h1));
    req_checks   = 5'(nchk) * 5'(PBC_BITS_PER_STEP * PBC_CHECKS_PER_BIT);
    perm         = (sleep_v == PBC_SLEEP_PERM);

    // pins: three stages, a change counts once the last two agree
    next_cur.demod_sync = {cur.demod_sync[1:0], demod_in};
    next_cur.poll_sync  = {cur.poll_sync[1:0], poll_sel_n_in};
    if (cur.demod_sync[1] == cur.demod_sync[2]) begin
      next_cur.demod_lvl = cur.demod_sync[2];
    end
    if (cur.poll_sync[1] == cur.poll_sync[2]) begin
      next_cur.poll_lvl = cur.poll_sync[2];
    end
    edge_seen = (next_cur.demod_lvl != cur.demod_lvl);
    forced    = ~cur.poll_lvl;
    poll_rise = next_cur.poll_lvl & ~cur.poll_lvl;

    // register writes
    if (wr_go) begin
      next_cur.bvalid = 1'b1;
      next_cur.bresp  = PBC_RESP_OKAY;
      case (s_axi_awaddr_in)
        PBC_OFF_OPCFG: begin
          wmerged        = pbc_merge(32'(cur.opcfg), s_axi_wdata_in, s_axi_wstrb_in);
          next_cur.opcfg = wmerged[PBC_OPCFG_W-1:0];
        end
        PBC_OFF_WIN: begin
          wmerged      = pbc_merge(32'(cur.win), s_axi_wdata_in, s_axi_wstrb_in);
          // only the two limit fields are stored, the bits around them read as zero
          next_cur.win = '0;
          next_cur.win[PBC_WIN_LO_LSB +: 5] = wmerged[PBC_WIN_LO_LSB +: 5];
          next_cur.win[PBC_WIN_HI_LSB +: 5] = wmerged[PBC_WIN_HI_LSB +: 5];
        end
        PBC_OFF_STATUS: begin
          next_cur.bresp = PBC_RESP_OKAY;
        end
        PBC_OFF_CMD: begin
          back_to_poll = s_axi_wstrb_in[0] & s_axi_wdata_in[PBC_CMD_POLL_BIT];
        end
        default: begin
          next_cur.bresp = PBC_RESP_SLVERR;
        end
      endcase
    end else if (cur.bvalid && s_axi_bready_in) begin
      next_cur.bvalid = 1'b0;
    end

    // sequencer
    case (cur.state)
      PBC_ST_SLEEP: begin
        if (base_tick && (cur.sleep_cnt != 18'h3FFFF)) begin
          next_cur.sleep_cnt = cur.sleep_cnt + 18'h00001;
        end
        if (forced) begin
          next_cur.state     = PBC_ST_STARTUP;
          next_cur.start_cnt = 16'h0000;
        end else if (!perm && (cur.sleep_cnt >= sleep_target)) begin
          next_cur.state     = PBC_ST_STARTUP;
          next_cur.start_cnt = 16'h0000;
        end
      end
      PBC_ST_STARTUP: begin
        // demodulator output is not trusted yet, edges are not looked at
        if (base_tick) begin
          next_cur.start_cnt = cur.start_cnt + 16'h0001;
        end
        if (base_tick && (cur.start_cnt == START_LAST)) begin
          next_cur.xcnt   = 3'h0;
          next_cur.icnt   = 6'h00;
          next_cur.armed  = 1'b0;
          next_cur.passes = 5'h00;
          if (forced || (req_checks == 5'h00)) begin
            next_cur.state = PBC_ST_RECEIVE;
          end else begin
            next_cur.state = PBC_ST_CHECK;
          end
        end
      end
      PBC_ST_CHECK: begin
        if (base_tick) begin
          next_cur.xcnt = xtick ? 3'h0 : cur.xcnt + 3'h1;
        end
        if (xtick && (cur.icnt != 6'h3F)) begin
          next_cur.icnt = cur.icnt + 6'h01;
        end
        // reaching the high limit means the interval already exceeds (hi-1) ticks
        if (cur.icnt >= 6'(hi_lim)) begin
          next_cur.state     = PBC_ST_SLEEP;
          next_cur.sleep_cnt = 18'h00000;
        end else if (edge_seen) begin
          next_cur.icnt = 6'h00;
          if (!cur.armed) begin
            // the first edge only starts the first interval
            next_cur.armed = 1'b1;
          end else if (cur.icnt < 6'(lo_lim)) begin
            next_cur.state     = PBC_ST_SLEEP;
            next_cur.sleep_cnt = 18'h00000;
          end else begin
            next_cur.passes = cur.passes + 5'h01;
            if ((cur.passes + 5'h01) >= req_checks) begin
              next_cur.state = PBC_ST_RECEIVE;
            end
          end
        end
      end
      PBC_ST_RECEIVE: begin
        next_cur.state = PBC_ST_RECEIVE;
      end
      default: begin
        next_cur.state = PBC_ST_SLEEP;
      end
    endcase

    // explicit return to polling: command write or release of the select pin
    if ((back_to_poll || poll_rise) && (cur.state != PBC_ST_SLEEP)) begin
      next_cur.state     = PBC_ST_SLEEP;
      next_cur.sleep_cnt = 18'h00000;
    end

    // register reads
    status[PBC_ST_STATE_LSB +: 2] = cur.state;
    status[PBC_ST_ACT_BIT]        = (cur.state != PBC_ST_SLEEP);
    status[PBC_ST_FORCE_BIT]      = forced;
    status[PBC_ST_PASS_LSB +: 5]  = cur.passes;
    status[PBC_ST_ICNT_LSB +: 6]  = cur.icnt;
    if (rd_go) begin
      next_cur.rvalid = 1'b1;
      next_cur.rresp  = PBC_RESP_OKAY;
      case (s_axi_araddr_in)
        PBC_OFF_OPCFG:  next_cur.rdata = 32'(cur.opcfg);
        PBC_OFF_WIN:    next_cur.rdata = 32'(cur.win);
        PBC_OFF_STATUS: next_cur.rdata = status;
        PBC_OFF_CMD:    next_cur.rdata = 32'h00000000;
        default: begin
          next_cur.rdata = 32'h00000000;
          next_cur.rresp = PBC_RESP_SLVERR;
        end
      endcase
    end else if (cur.rvalid && s_axi_rready_in) begin
      next_cur.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cur <= REGS_RST;
    end else if (ce_in) begin
      cur <= next_cur;
    end
  end

  assign activity_indicator_out = (cur.state != PBC_ST_SLEEP);
  assign sig_proc_en_out        = (cur.state != PBC_ST_SLEEP);
  assign receiving_out          = (cur.state == PBC_ST_RECEIVE);
  assign s_axi_bvalid_out       = cur.bvalid;
  assign s_axi_bresp_out        = cur.bresp;
  assign s_axi_rvalid_out       = cur.rvalid;
  assign s_axi_rdata_out        = cur.rdata;
  assign s_axi_rresp_out        = cur.rresp;

endmodule : pbc_ctrl

// [tb/pbc_tx_model.sv]
// transmitter model: square wave on the demodulator pin
// assumes the bench sets the half period in clocks before enabling
`timescale 1ns/10ps
module pbc_tx_model (
  input  wire logic clk_in,
  input  wire logic en_in,
  input  wire logic [31:0] half_in,
  output logic      demod_out
);
  int cnt;
  initial begin
    demod_out = 1'b0;
    cnt = 0;
  end
  // preburst lasts as long as the bench enables it
  always @(posedge clk_in) begin
    if (!en_in) begin
      cnt <= 0;
    end else if (cnt >= half_in - 1) begin
      cnt <= 0;
      demod_out <= !demod_out;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pbc_tx_model

// [tb/pbc_ctrl_chk.sv]
// port checker for the polling controller
// assumes one clock domain; bound into every pbc_ctrl
`timescale 1ns/10ps
module pbc_ctrl_chk
  import pbc_pkg::*;
#(
  parameter int VARIANT_DIV   = PBC_DIV_STD,
  parameter int STARTUP_TICKS = PBC_STARTUP_TICKS
) (
  input wire logic        ref_clk_in,
  input wire logic        resetn_in,
  input wire logic        ce_in,
  input wire logic        poll_sel_n_in,
  input wire logic        activity_indicator_out,
  input wire logic        sig_proc_en_out,
  input wire logic        receiving_out,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in
);
  logic [3:0] wr_age;
  logic [3:0] pin_age;
  // ages saturate so a long quiet spell never wraps into a false excuse
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_age  <= 4'hF;
      pin_age <= 4'hF;
    end else begin
      wr_age  <= (s_axi_awvalid_in && s_axi_awready_out) ? 4'h0 :
                 (wr_age == 4'hF) ? wr_age : wr_age + 4'h1;
      pin_age <= !poll_sel_n_in ? 4'h0 : (pin_age == 4'hF) ? pin_age : pin_age + 4'h1;
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_wr_take;
    s_axi_awvalid_in && s_axi_wvalid_in && s_axi_awready_out && ce_in;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid_in && s_axi_arready_out && ce_in;
  endsequence
  sequence s_pin_low;
    (!poll_sel_n_in && ce_in) [*6];
  endsequence
  AST_PROC_FOLLOWS: assert property (sig_proc_en_out == activity_indicator_out)
    else $error("processing enable differs from activity");
  AST_RECV_ACTIVE: assert property (receiving_out |-> activity_indicator_out)
    else $error("receiving while activity low");
  AST_RECV_HOLD: assert property ($past(resetn_in) && $fell(receiving_out) |->
    (wr_age < 4'h3 || pin_age < 4'h8))
    else $error("receive left without command");
  AST_FORCE_WAKE: assert property (s_pin_low |-> activity_indicator_out)
    else $error("held select pin did not wake");
  AST_AW_W_PAIR: assert property (s_axi_awready_out == s_axi_wready_out)
    else $error("awready and wready differ");
  AST_B_NEXT: assert property (s_wr_take |=> s_axi_bvalid_out)
    else $error("write response late");
  AST_R_NEXT: assert property (s_rd_take |=> s_axi_rvalid_out)
    else $error("read response late");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
endmodule : pbc_ctrl_chk
bind pbc_ctrl pbc_ctrl_chk #(.VARIANT_DIV(VARIANT_DIV), .STARTUP_TICKS(STARTUP_TICKS)) u_chk (
  .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .poll_sel_n_in(poll_sel_n_in),
  .activity_indicator_out(activity_indicator_out), .sig_proc_en_out(sig_proc_en_out),
  .receiving_out(receiving_out), .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rdata_out(s_axi_rdata_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in));

// [tb/pbc_ctrl_tb.sv]
// testbench for the polling controller: register tasks plus transmitter model
// assumes a small divider so sleep spans stay short
`timescale 1ns/10ps
module pbc_ctrl_tb;
  import pbc_pkg::*;
  localparam int DIV = 4;
  logic        ref_clk_in, resetn_in, ce_in, demod_in, poll_sel_n_in;
  logic        activity_indicator_out, sig_proc_en_out, receiving_out;
  logic [3:0]  s_axi_awaddr_in, s_axi_araddr_in, s_axi_wstrb_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd;
  logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out;
  logic        s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out;
  logic        s_axi_rvalid_out, s_axi_rready_in, tx_en;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rs;
  int          err_total, compares, cyc, c, t0, falls, rx_seen, tx_half;
  int          codes[5] = '{0, 1, 2, 3, 1};
  int          rates[5] = '{0, 0, 1, 2, 3};
  int          pers[5]  = '{18, 15, 22, 18, 20};
  int          bad[2]   = '{10, 30};

  pbc_ctrl #(.VARIANT_DIV(DIV), .STARTUP_TICKS(2)) dut (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .ce_in(ce_in), .demod_in(demod_in),
    .poll_sel_n_in(poll_sel_n_in), .activity_indicator_out(activity_indicator_out),
    .sig_proc_en_out(sig_proc_en_out), .receiving_out(receiving_out),
    .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in),
    .s_axi_wstrb_in(s_axi_wstrb_in), .s_axi_wvalid_in(s_axi_wvalid_in),
    .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
    .s_axi_araddr_in(s_axi_araddr_in), .s_axi_arvalid_in(s_axi_arvalid_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rresp_out(s_axi_rresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
    .s_axi_rready_in(s_axi_rready_in));
  pbc_tx_model u_tx (.clk_in(ref_clk_in), .en_in(tx_en), .half_in(tx_half), .demod_out(demod_in));

  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic final_report;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    // ceiling well above the planned run of about 60000 cycles
    if (cyc == 90000) begin
      err_total++;
      $display("FAIL %0t watchdog expired", $time);
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready is raised a cycle late on purpose so the response must stand
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr_in  <= a;
    s_axi_wdata_in   <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in  <= 1'b1;
    do @(posedge ref_clk_in); while (s_axi_awready_out !== 1'b1);
    s_axi_awvalid_in <= 1'b0;
    s_axi_wvalid_in  <= 1'b0;
    @(posedge ref_clk_in);
    s_axi_bready_in <= 1'b1;
    do @(posedge ref_clk_in); while (s_axi_bvalid_out !== 1'b1);
    rs = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a);
    s_axi_araddr_in  <= a;
    s_axi_arvalid_in <= 1'b1;
    do @(posedge ref_clk_in); while (s_axi_arready_out !== 1'b1);
    s_axi_arvalid_in <= 1'b0;
    @(posedge ref_clk_in);
    s_axi_rready_in <= 1'b1;
    do @(posedge ref_clk_in); while (s_axi_rvalid_out !== 1'b1);
    rd = s_axi_rdata_out;
    rs = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : axi_rd

  task automatic wait_for(input bit rx, input logic v, input int n);
    c = 0;
    while (c < n && (rx ? receiving_out : activity_indicator_out) !== v) begin
      @(posedge ref_clk_in);
      c++;
    end
  endtask : wait_for

  initial begin
    {resetn_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, tx_en, s_axi_awaddr_in, s_axi_araddr_in} = '0;
    {err_total, compares, cyc} = '0;
    {ce_in, poll_sel_n_in} = 2'b11;
    s_axi_wstrb_in = 4'hF;
    s_axi_wdata_in = 32'h0;
    tx_half = 8;
    repeat (2) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    t0 = cyc;
    axi_rd(PBC_OFF_OPCFG);
    chk(rd, 32'(PBC_OPCFG_RST));
    axi_rd(4'h2);
    chk(rd, 32'h00000000);
    chk(32'(rs), 32'(PBC_RESP_SLVERR));
    axi_wr(4'h2, 32'hFFFF_FFFF);
    chk(32'(rs), 32'(PBC_RESP_SLVERR));
    wait_for(0, 1, 6000);
    chk(32'(cyc - t0 >= 1024 * DIV - 4 && cyc - t0 <= 1024 * DIV + 8), 32'h1);
    wait_for(0, 0, 2000);
    chk(32'(activity_indicator_out), 32'h0); // back to sleep
    t0 = cyc;
    axi_wr(PBC_OFF_OPCFG, 32'h061);
    chk(32'(rs), 32'(PBC_RESP_OKAY));
    wait_for(0, 1, 40000);
    chk(32'(cyc - t0 >= 8192 * DIV - 8 && cyc - t0 <= 8192 * DIV + 12), 32'h1);
    axi_wr(PBC_OFF_WIN, 32'hFFFF_FFFF);
    axi_rd(PBC_OFF_WIN);
    chk(rd, 32'h1F1F);
    axi_wr(PBC_OFF_WIN, 32'h180E);
    axi_wr(PBC_OFF_OPCFG, 32'h05F);
    axi_wr(PBC_OFF_CMD, 32'h1);
    repeat (1000) @(posedge ref_clk_in);
    chk(32'(activity_indicator_out), 32'h0);
    poll_sel_n_in <= 1'b0;
    wait_for(1, 1, 200);
    chk(32'(receiving_out), 32'h1);
    axi_rd(PBC_OFF_OPCFG);
    chk(rd, 32'h05F); // settings kept
    poll_sel_n_in <= 1'b1;
    wait_for(0, 0, 20);
    chk(32'(activity_indicator_out), 32'h0);
    axi_wr(PBC_OFF_OPCFG, 32'h040);
    wait_for(0, 1, 20);
    chk(32'(activity_indicator_out), 32'h1);
    for (int i = 0; i < 5; i++) begin
      tx_en <= 1'b0;
      axi_wr(PBC_OFF_OPCFG, 32'(rates[i] * 256 + codes[i] * 64));
      axi_wr(PBC_OFF_CMD, 32'h1);
      tx_half <= pers[i] * (8 >> rates[i]) * DIV;
      tx_en <= 1'b1;
      wait_for(1, 1, 8000);
      chk(32'(receiving_out), 32'h1);
      axi_rd(PBC_OFF_STATUS);
      chk(rd & 32'h1F07, 32'h7 + 32'(6 * codes[i] * 256));
      tx_en <= 1'b0;
      repeat (300) @(posedge ref_clk_in);
      chk(32'(receiving_out), 32'h1);
    end
    axi_wr(PBC_OFF_OPCFG, 32'h3C0); // 9 check bits with low limit 14
    foreach (bad[i]) begin
      tx_half <= bad[i] * DIV;
      axi_wr(PBC_OFF_CMD, 32'h1);
      tx_en <= 1'b1;
      {falls, rx_seen} = '0;
      repeat (3000) begin
        @(posedge ref_clk_in);
        rx_seen += int'(receiving_out === 1'b1);
        falls += int'(activity_indicator_out === 1'b0);
      end
      chk(32'(rx_seen), 32'h0); // out of window fails
      chk(32'(falls > 0), 32'h1);
      tx_en <= 1'b0;
    end
    final_report();
  end
endmodule : pbc_ctrl_tb
